// ===== design/bfss_regs.svh
`ifndef BFSS_REGS_SVH
`define BFSS_REGS_SVH
// ------------------------------------------------------------
// Timing constants (10 MHz regulation clock, 100 ns period)
// ------------------------------------------------------------
`define BFSS_CLK_HZ          10000000
`define BFSS_MS_NS           1000000
`define BFSS_CLK_PERIOD_NS   100
// One millisecond in clock cycles
`define BFSS_MS_CYCLES       (`BFSS_MS_NS / `BFSS_CLK_PERIOD_NS)
// Debounce base 12.5 us = 12500 ns, least time rounds up
`define BFSS_DEB_BASE_NS     12500
`define BFSS_DEB_BASE_CYC    ((`BFSS_DEB_BASE_NS + `BFSS_CLK_PERIOD_NS - 1) / `BFSS_CLK_PERIOD_NS)
// Hiccup pause 200 ms
`define BFSS_HICCUP_MS       200
// Turn-on / turn-off delay field width (0..63 ms)
`define BFSS_DLY_W           6
// Soft-start durations in ms per setting
`define BFSS_SS_MS_0         8'h01
`define BFSS_SS_MS_1         8'h02
`define BFSS_SS_MS_2         8'h04
`define BFSS_SS_MS_3         8'h08
// Millisecond counter width
`define BFSS_MSCNT_W         14
// Delay counter width (ms units)
`define BFSS_DCNT_W          8
// Debounce counter width
`define BFSS_DEBCNT_W        12
// Number of monitor fault flags
`define BFSS_NMON            9
`endif

// ===== design/bfss_pkg.sv
package bfss_pkg;
  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF, ST_LDO, ST_SELF_TEST, ST_ON_DELAY, ST_SOFT_START, ST_RUN,
    ST_OFF_DELAY, ST_MON_FAULT, ST_HICCUP, ST_LATCH, ST_THERM_OFF
  } bfss_state_t;

  // ------------------------------------------------------------
  // Asynchronous comparator flags
  // ------------------------------------------------------------
  typedef struct packed {
    logic en_above_ldo;
    logic en_above_buck;
    logic input_lockout_ok;
    logic out_under;
    logic out_over;
    logic bandgap_mismatch;
    logic power_ground_over;
    logic power_ground_under;
    logic reset_pin_high;
    logic supply_over;
    logic supply_under;
    logic clock_fault;
    logic therm_monitor;
    logic therm_regulation;
    logic therm_cool;
    logic hs_oc;
    logic hs_oc_secondary;
    logic ls_oc;
    logic neg_oc;
  } bfss_flags_t;

  // ------------------------------------------------------------
  // Factory configuration
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] soft_start_sel;
    logic [5:0] on_delay_ms;
    logic [5:0] off_delay_ms;
    logic [1:0] debounce_sel;
    logic       hiccup_en;
  } bfss_cfg_t;
endpackage : bfss_pkg

// ===== design/bfss_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser bank for asynchronous comparator flags
module bfss_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // ------------------------------------------------------------
  // Next values; first stage feeds only the second
  // ------------------------------------------------------------
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule : bfss_sync

// ===== design/bfss_core.sv
`timescale 1ns/100ps
`include "bfss_regs.svh"
// Overview of operation
// (R01) Soft-start ramp uses one of four durations after turn-on delay.
// (R02) After enable rises, wait programmable 0 to 63 ms before soft-start.
// (R03) Enable low drops power-good at once, regulation stops after off delay.
// (R04) Output undervoltage disables regulation and pulls power-good low.
// (R05) Output overvoltage disables regulation and pulls power-good low.
// (R06) Start-up needs input lockout released and enable above buck level.
// (R07) Enable low is off; LDO band runs rail; buck band starts sequence.
// (R08) Power-good is high only without monitor or regulation fault.
// (R09) Monitor faults act only after persisting for programmable debounce time.
// (R10) Bandgap mismatch raises a monitor fault.
// (R11) Power-ground over or under difference raises a monitor fault.
// (R12) Reset pin high during start-up drops power-good and abandons start.
// (R13) Supply over or under threshold raises a monitor fault.
// (R14) Clock frequency or stuck clock raises a monitor fault.
// (R15) Sequencer steps self test to run; faults go to monitor-fault state.
// (R16) Redundant sequencer copy must agree, else state-machine fault.
// (R17) Monitor thermal trip shuts output down until enable is toggled.
// (R18) Regulation thermal trip disables all until cool-down indication.
// (R19) Primary high-side overcurrent cuts high side for rest of cycle.
// (R20) Secondary high-side overcurrent latches buck off.
// (R21) Low-side overcurrent latches off; negative overcurrent cuts low side only.
// (R22) Hiccup response pauses fixed time, then retries until fault clears.
// (R23) Latch-off response stays off until enable toggles or power cycles.
// (R24) Comparator flags pass two flip-flops before any logic uses them.
module bfss_core #(
  parameter int HICCUP_MS = `BFSS_HICCUP_MS,
  parameter int MS_CYCLES = `BFSS_MS_CYCLES
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_sys_rst,
  input  wire bfss_pkg::bfss_flags_t i_flags,
  input  wire bfss_pkg::bfss_cfg_t   i_cfg,
  input  wire logic                i_cycle_start,
  output logic                     o_fault_power_good_n,
  output logic                     o_ldo_enable,
  output logic                     o_regulate,
  output logic                     o_soft_start,
  output logic                     o_monitor_enable,
  output logic                     o_high_side_off,
  output logic                     o_low_side_off,
  output logic                     o_state_machine_fault,
  output logic                     o_monitor_fault
);
  bfss_pkg::bfss_flags_t f;

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  // Every comparator flag is async to the regulation clock [R24]
  bfss_sync #(.W($bits(bfss_pkg::bfss_flags_t))) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_flags),
    .o_sync    (f)
  );

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  logic [`BFSS_MSCNT_W-1:0] ms_cnt_reg;
  logic [`BFSS_MSCNT_W-1:0] ms_cnt_next;
  logic                     ms_tick;

  always_comb begin
    ms_tick     = (ms_cnt_reg == `BFSS_MSCNT_W'(MS_CYCLES - 1));
    ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) ms_cnt_reg <= '0;
    else           ms_cnt_reg <= ms_cnt_next;
  end

  // ------------------------------------------------------------
  // Monitor fault debounce
  // ------------------------------------------------------------
  logic                       mon_raw;
  logic [`BFSS_DEBCNT_W-1:0]  deb_cnt_reg;
  logic [`BFSS_DEBCNT_W-1:0]  deb_cnt_next;
  logic [`BFSS_DEBCNT_W-1:0]  deb_limit;
  logic                       mon_flt_reg;
  logic                       mon_flt_next;
  logic                       sm_flt_reg;

  // Monitor sources; output window faults are not among them and act only in run, via the sequencer
  always_comb begin
    mon_raw = f.bandgap_mismatch                               // [R10]
            | f.power_ground_over | f.power_ground_under       // [R11]
            | f.supply_over | f.supply_under                   // [R13]
            | f.clock_fault                                    // [R14]
            | sm_flt_reg;                                      // [R16]
  end

  // Debounce is 12.5 us doubled per setting; a short glitch resets the count [R09]
  always_comb begin
    deb_limit    = `BFSS_DEBCNT_W'(`BFSS_DEB_BASE_CYC) << i_cfg.debounce_sel;
    deb_cnt_next = '0;
    mon_flt_next = 1'b0;
    if (mon_raw) begin
      if (deb_cnt_reg >= deb_limit - 1'b1) begin
        deb_cnt_next = deb_cnt_reg;
        mon_flt_next = 1'b1;
      end else begin
        deb_cnt_next = deb_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      deb_cnt_reg <= '0;
      mon_flt_reg <= 1'b0;
    end else begin
      deb_cnt_reg <= deb_cnt_next;
      mon_flt_reg <= mon_flt_next;
    end
  end

  // ------------------------------------------------------------
  // Sequencer and its redundant copy
  // ------------------------------------------------------------
  bfss_pkg::bfss_state_t st_reg, st_next, shadow_reg;
  logic [`BFSS_DCNT_W-1:0] dcnt_reg;
  logic [`BFSS_DCNT_W-1:0] dcnt_next;
  logic [`BFSS_DCNT_W-1:0] ss_ms;
  logic                    en_seen_low_reg;
  logic                    en_seen_low_next;
  logic                    reg_fault;
  logic                    latch_fault;
  logic                    ms_load;

  // Soft-start duration from four factory settings [R01]
  always_comb begin
    case (i_cfg.soft_start_sel)
      2'h0:    ss_ms = `BFSS_SS_MS_0;
      2'h1:    ss_ms = `BFSS_SS_MS_1;
      2'h2:    ss_ms = `BFSS_SS_MS_2;
      default: ss_ms = `BFSS_SS_MS_3;
    endcase
  end

  // Regulation faults; hiccup-eligible vs always-latching
  always_comb begin
    reg_fault   = f.out_under | f.out_over;              // [R04] [R05]
    latch_fault = f.hs_oc_secondary | f.ls_oc;           // [R20] [R21]
  end

  always_comb begin
    st_next          = st_reg;
    dcnt_next        = dcnt_reg;
    en_seen_low_next = en_seen_low_reg;
    ms_load          = 1'b0;
    if (ms_tick && dcnt_reg != '0) dcnt_next = dcnt_reg - 1'b1;
    case (st_reg)
      bfss_pkg::ST_OFF: begin
        en_seen_low_next = 1'b1;
        if (f.en_above_ldo) st_next = bfss_pkg::ST_LDO;            // [R07]
      end
      bfss_pkg::ST_LDO: begin
        if (!f.en_above_ldo) st_next = bfss_pkg::ST_OFF;
        else if (f.en_above_buck && f.input_lockout_ok)            // [R06]
          st_next = bfss_pkg::ST_SELF_TEST;
      end
      bfss_pkg::ST_SELF_TEST: begin
        if (f.reset_pin_high) st_next = bfss_pkg::ST_MON_FAULT;     // [R12]
        else if (mon_flt_reg) st_next = bfss_pkg::ST_MON_FAULT;
        else begin
          st_next   = bfss_pkg::ST_ON_DELAY;
          dcnt_next = `BFSS_DCNT_W'(i_cfg.on_delay_ms);            // [R02]
        end
      end
      bfss_pkg::ST_ON_DELAY: begin
        if (!f.en_above_buck) st_next = bfss_pkg::ST_LDO;
        else if (f.reset_pin_high) st_next = bfss_pkg::ST_MON_FAULT; // [R12]
        else if (dcnt_reg == '0) begin
          st_next   = bfss_pkg::ST_SOFT_START;
          dcnt_next = ss_ms;                                       // [R01]
        end
      end
      bfss_pkg::ST_SOFT_START: begin
        if (!f.en_above_buck) st_next = bfss_pkg::ST_LDO;
        else if (latch_fault) st_next = bfss_pkg::ST_LATCH;
        else if (dcnt_reg == '0) st_next = bfss_pkg::ST_RUN;
      end
      bfss_pkg::ST_RUN: begin
        if (!f.en_above_buck) begin
          st_next   = bfss_pkg::ST_OFF_DELAY;
          dcnt_next = `BFSS_DCNT_W'(i_cfg.off_delay_ms);           // [R03]
        end else if (latch_fault || f.therm_monitor)               // [R17] [R20] [R21]
          st_next = bfss_pkg::ST_LATCH;
        else if (reg_fault) begin
          if (i_cfg.hiccup_en) begin
            st_next   = bfss_pkg::ST_HICCUP;                       // [R22]
            ms_load   = 1'b1;
          end else st_next = bfss_pkg::ST_LATCH;                   // [R23]
        end else if (mon_flt_reg) st_next = bfss_pkg::ST_MON_FAULT; // [R15]
      end
      bfss_pkg::ST_OFF_DELAY: begin
        if (dcnt_reg == '0) st_next = bfss_pkg::ST_LDO;            // [R03]
      end
      bfss_pkg::ST_MON_FAULT: begin
        if (!f.en_above_buck) st_next = bfss_pkg::ST_LDO;
      end
      bfss_pkg::ST_HICCUP: begin
        if (!f.en_above_buck) st_next = bfss_pkg::ST_LDO;
        else if (dcnt_reg == '0) st_next = bfss_pkg::ST_SELF_TEST; // [R22]
      end
      bfss_pkg::ST_LATCH: begin
        en_seen_low_next = 1'b0;
        if (!f.en_above_buck) st_next = bfss_pkg::ST_LDO;          // [R23]
      end
      bfss_pkg::ST_THERM_OFF: begin
        if (f.therm_cool) st_next = bfss_pkg::ST_OFF;              // [R18]
      end
      default: st_next = bfss_pkg::ST_OFF;
    endcase
    if (ms_load) dcnt_next = `BFSS_DCNT_W'(HICCUP_MS);
    // Top-level overrides: enable off wins outside off delay and thermal off; regulation thermal trip always wins
    if (!f.en_above_ldo && st_reg != bfss_pkg::ST_THERM_OFF
        && st_reg != bfss_pkg::ST_OFF_DELAY)
      st_next = bfss_pkg::ST_OFF;                                  // [R07]
    if (f.therm_regulation) st_next = bfss_pkg::ST_THERM_OFF;      // [R18]
  end

  // Redundant copy loads the same next state on the same edge [R16]
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_reg          <= bfss_pkg::ST_OFF;
      shadow_reg      <= bfss_pkg::ST_OFF;
      dcnt_reg        <= '0;
      en_seen_low_reg <= 1'b0;
    end else begin
      st_reg          <= st_next;
      shadow_reg      <= st_next;
      dcnt_reg        <= dcnt_next;
      en_seen_low_reg <= en_seen_low_next;
    end
  end

  logic sm_flt_next;

  // Any disagreement between the two copies is a state-machine fault [R16]
  always_comb begin
    sm_flt_next = (st_reg != shadow_reg);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) sm_flt_reg <= 1'b0;
    else           sm_flt_reg <= sm_flt_next;
  end

  // ------------------------------------------------------------
  // Switch controls and registered outputs
  // ------------------------------------------------------------
  logic hs_off_reg;
  logic hs_off_next;
  logic pg_n_reg;
  logic pg_n_next;
  logic reg_on;
  logic ldo_next;
  logic ss_next;
  logic mon_en_next;
  logic ls_off_next;

  // High side stays off from trip until the next switching cycle [R19]
  always_comb begin
    if (f.hs_oc)             hs_off_next = 1'b1;
    else if (i_cycle_start)  hs_off_next = 1'b0;
    else                     hs_off_next = hs_off_reg;
  end

  // Power-good only in run with no fault present; the flop holds the pin level itself
  always_comb begin
    reg_on      = (st_next == bfss_pkg::ST_SOFT_START) || (st_next == bfss_pkg::ST_RUN)
                || (st_next == bfss_pkg::ST_OFF_DELAY);
    pg_n_next   = (st_next == bfss_pkg::ST_RUN) && !mon_flt_reg && f.en_above_buck;  // [R08]
    ldo_next    = (st_next != bfss_pkg::ST_OFF) && (st_next != bfss_pkg::ST_THERM_OFF);
    ss_next     = (st_next == bfss_pkg::ST_SOFT_START);
    mon_en_next = (st_next != bfss_pkg::ST_THERM_OFF);                               // [R18]
    ls_off_next = f.neg_oc || !reg_on;                                               // [R21]
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hs_off_reg            <= 1'b1;
      pg_n_reg              <= 1'b0;
      o_regulate            <= 1'b0;
      o_ldo_enable          <= 1'b0;
      o_soft_start          <= 1'b0;
      o_monitor_enable      <= 1'b0;
      o_low_side_off        <= 1'b1;
      o_state_machine_fault <= 1'b0;
      o_monitor_fault       <= 1'b0;
    end else begin
      hs_off_reg            <= hs_off_next;
      pg_n_reg              <= pg_n_next;
      o_regulate            <= reg_on;
      o_ldo_enable          <= ldo_next;
      o_soft_start          <= ss_next;
      o_monitor_enable      <= mon_en_next;
      o_low_side_off        <= ls_off_next;
      o_state_machine_fault <= sm_flt_reg;
      o_monitor_fault       <= mon_flt_reg;
    end
  end

  assign o_fault_power_good_n = pg_n_reg;
  assign o_high_side_off      = hs_off_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_run_enable_drop;
    st_reg == bfss_pkg::ST_RUN && !f.en_above_buck && f.en_above_ldo && !f.therm_regulation;
  endsequence

  a_pg_drop_enable: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R03]
    s_run_enable_drop |=> !o_fault_power_good_n && o_regulate)
    else $error("power-good not dropped on enable low");

  a_pg_needs_run: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R08]
    o_fault_power_good_n |-> $past(st_next) == bfss_pkg::ST_RUN)
    else $error("power-good high outside run");

  a_debounce_short: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R09]
    $rose(mon_raw) |=> !mon_flt_reg)
    else $error("monitor fault without debounce");

  a_hs_cut_trip: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R19]
    f.hs_oc |=> o_high_side_off)
    else $error("high side not cut on overcurrent");

  a_latch_second_oc: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R20]
    st_reg == bfss_pkg::ST_RUN && f.en_above_ldo && f.en_above_buck && f.hs_oc_secondary
    && !f.therm_regulation |=> st_reg == bfss_pkg::ST_LATCH)
    else $error("secondary overcurrent did not latch");

  a_latch_stays: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R23]
    st_reg == bfss_pkg::ST_LATCH && f.en_above_buck && f.en_above_ldo && !f.therm_regulation
    |=> st_reg == bfss_pkg::ST_LATCH)
    else $error("latch-off left while enabled");

  a_therm_off_all: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R18]
    f.therm_regulation |=> st_reg == bfss_pkg::ST_THERM_OFF && !o_regulate && !o_monitor_enable)
    else $error("regulation thermal trip not honoured");

  a_lockout_block: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R06]
    st_reg == bfss_pkg::ST_LDO && !f.input_lockout_ok |=> st_reg != bfss_pkg::ST_SELF_TEST)
    else $error("start-up without lockout release");

  a_reset_pin_abort: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R12]
    st_reg == bfss_pkg::ST_ON_DELAY && f.reset_pin_high && f.en_above_buck && f.en_above_ldo
    && !f.therm_regulation |=> st_reg == bfss_pkg::ST_MON_FAULT)
    else $error("start-up not abandoned on reset pin high");

  a_sm_agree: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R16]
    st_reg != shadow_reg |=> sm_flt_reg)
    else $error("state mismatch not flagged");
endmodule : bfss_core

// ===== verif/bfss_pmic_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Downstream PMIC enable input
// ------------------------------------------------------------
module bfss_pmic_model (
  input  wire logic i_ref_clk,
  input  wire logic i_enable,
  output logic      o_on
);
  logic [1:0] sync_reg;
  logic [1:0] sync_next;

  // Enable pin sampled through two flops, so the PMIC reacts late, never early
  always_comb begin
    sync_next = {sync_reg[0], i_enable};
  end

  // Register only
  always_ff @(posedge i_ref_clk) begin
    sync_reg <= sync_next;
  end

  assign o_on = sync_reg[1];
endmodule : bfss_pmic_model

// ===== verif/testbench.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench for the sequencer core
// ------------------------------------------------------------
module testbench;
  typedef struct {int k; logic mon;} bfss_row_t;
  logic                  i_ref_clk;
  logic                  i_sys_rst;
  logic                  i_cycle_start;
  bfss_pkg::bfss_flags_t flags;
  bfss_pkg::bfss_cfg_t   cfg;
  logic                  pg_n, ldo, reg_on, ss, mon_en, hs_off, ls_off, sm_f, mon_f, pmic_on;
  int                    mismatches, check_count, n;
  // Flag bit: 13 bandgap, 12/11 ground, 9/8 supply, 7 clock, 15/14 out, 6 therm, 2 hs2, 1 ls
  bfss_row_t rows[11] = '{'{13,1}, '{12,1}, '{11,1}, '{9,1}, '{8,1}, '{7,1},
                          '{15,0}, '{14,0}, '{6,0}, '{2,0}, '{1,0}};

  // Short millisecond and hiccup figures keep the run small
  bfss_core #(.HICCUP_MS(3), .MS_CYCLES(10)) dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_flags(flags), .i_cfg(cfg),
    .i_cycle_start(i_cycle_start), .o_fault_power_good_n(pg_n), .o_ldo_enable(ldo),
    .o_regulate(reg_on), .o_soft_start(ss), .o_monitor_enable(mon_en), .o_high_side_off(hs_off),
    .o_low_side_off(ls_off), .o_state_machine_fault(sm_f), .o_monitor_fault(mon_f));
  bfss_pmic_model pmic (.i_ref_clk(i_ref_clk), .i_enable(pg_n), .o_on(pmic_on));

  // 100 ns clock
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // Inputs move a fixed 10 ns after the edge, clear of sampling
  task tick;
    @(posedge i_ref_clk);
    #10;
  endtask : tick

  task rst;
    i_sys_rst = 1'b1;
    flags = '0;
    repeat (6) tick;
    i_sys_rst = 1'b0;
  endtask : rst

  // Bounded wait for power-good; running out ends the run
  task wait_pg(input int lim, output int cnt);
    cnt = 0;
    while (pg_n !== 1'b1 && cnt < lim) begin
      tick;
      cnt++;
    end
    if (cnt >= lim) begin
      mismatches++;
      report_and_stop;
    end
  endtask : wait_pg

  task bring_up;
    rst;
    flags = 19'h70000;
    wait_pg(400, n);
  endtask : bring_up

  initial begin
    mismatches = 0;
    check_count = 0;
    i_cycle_start = 1'b0;
    i_sys_rst = 1'b1;
    flags = '0;
    cfg = '0;
    cfg.off_delay_ms = 6'h01;
    rst;
    check_bit(pg_n, 1'b0);
    check_bit(hs_off, 1'b1);
    check_bit(ls_off, 1'b1);
    // Each fault from run: monitor faults flag, regulation faults latch off
    foreach (rows[i]) begin
      bring_up;
      repeat (3) tick;
      check_bit(pmic_on, 1'b1);
      flags[rows[i].k] = 1'b1;
      repeat (300) tick;
      check_bit(pg_n, 1'b0);
      check_bit(pmic_on, 1'b0);
      if (rows[i].mon) check_bit(mon_f, 1'b1);
      else check_bit(reg_on, 1'b0);
      flags[rows[i].k] = 1'b0;
      repeat (50) tick;
      if (!rows[i].mon) check_bit(pg_n, 1'b0);
    end
    // Start-up timing: on delay 3 ms, soft-start setting 1 (2 ms)
    cfg.on_delay_ms = 6'h03;
    cfg.soft_start_sel = 2'h1;
    cfg.off_delay_ms = 6'h02;
    rst;
    flags = 19'h70000;
    repeat (20) tick;
    check_bit(reg_on, 1'b0);
    repeat (27) tick;
    check_bit(ss, 1'b1);
    wait_pg(200, n);
    check_bit(n >= 3 && n <= 40, 1'b1);
    // Enable drop: power-good at once, regulation holds for the off delay
    flags[17] = 1'b0;
    repeat (4) tick;
    check_bit(pg_n, 1'b0);
    check_bit(reg_on, 1'b1);
    repeat (12) tick;
    check_bit(reg_on, 1'b1);
    repeat (30) tick;
    check_bit(reg_on, 1'b0);
    check_bit(ldo, 1'b1);
    // Debounce setting 1 is 250 cycles: shorter faults vanish
    cfg = '0;
    cfg.debounce_sel = 2'h1;
    bring_up;
    flags[13] = 1'b1;
    repeat (200) tick;
    flags[13] = 1'b0;
    repeat (10) tick;
    check_bit(mon_f, 1'b0);
    check_bit(pg_n, 1'b1);
    flags[13] = 1'b1;
    repeat (240) tick;
    check_bit(pg_n, 1'b1);
    repeat (20) tick;
    check_bit(mon_f, 1'b1);
    flags[13] = 1'b0;
    // Primary high-side trip cuts the high side until the next cycle start
    bring_up;
    i_cycle_start = 1'b1;
    tick;
    i_cycle_start = 1'b0;
    repeat (2) tick;
    check_bit(hs_off, 1'b0);
    flags[3] = 1'b1;
    tick;
    flags[3] = 1'b0;
    repeat (4) tick;
    check_bit(hs_off, 1'b1);
    check_bit(reg_on, 1'b1);
    i_cycle_start = 1'b1;
    tick;
    i_cycle_start = 1'b0;
    repeat (2) tick;
    check_bit(hs_off, 1'b0);
    // Negative trip only opens the low side
    check_bit(ls_off, 1'b0);
    flags[0] = 1'b1;
    repeat (4) tick;
    check_bit(ls_off, 1'b1);
    check_bit(pg_n, 1'b1);
    flags[0] = 1'b0;
    // Hiccup: pause, then retry on its own
    cfg.hiccup_en = 1'b1;
    bring_up;
    flags[14] = 1'b1;
    repeat (10) tick;
    check_bit(reg_on, 1'b0);
    flags[14] = 1'b0;
    wait_pg(300, n);
    check_bit(pg_n, 1'b1);
    // Regulation thermal trip holds everything off until cool-down
    flags[5] = 1'b1;
    repeat (6) tick;
    check_bit(mon_en, 1'b0);
    flags[5] = 1'b0;
    repeat (50) tick;
    check_bit(reg_on, 1'b0);
    // Cool-down indication lets the whole start-up run again
    flags[4] = 1'b1;
    wait_pg(200, n);
    check_bit(mon_en, 1'b1);
    check_bit(pg_n, 1'b1);
    // Reset pin high at start-up, with input lockout released
    rst;
    flags = 19'h70400;
    repeat (200) tick;
    check_bit(pg_n, 1'b0);
    check_bit(reg_on, 1'b0);
    // Reset pin seen high during the turn-on delay also abandons start-up
    cfg.on_delay_ms = 6'h05;
    rst;
    flags = 19'h70000;
    repeat (15) tick;
    flags[10] = 1'b1;
    repeat (60) tick;
    check_bit(pg_n, 1'b0);
    check_bit(reg_on, 1'b0);
    rst;
    flags = 19'h60000;
    repeat (100) tick;
    check_bit(ldo, 1'b1);
    check_bit(reg_on, 1'b0);
    check_bit(sm_f, 1'b0);
    report_and_stop;
  end
endmodule : testbench
